// File: rtl/phy_host.sv
// Implementation choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Operation
// - reference clock kept between 12 and 52 MHz
// - escape clock generated below 20 MHz
// - escape clock chosen as near 20 MHz
// - spread spectrum driven from control bit
// - escape request driven on escape clock
// - turnaround or force receive on lane 0
// - trigger sent; received trigger captured
// - clock lane fast request on word clock
// - fast request doubles as word valid
// - upper byte valid marks high byte
// - deskew request driven per lane
// - low power bytes sent with valid/ready
// - sleep enter/exit per lane, status read
module phy_host (
	// system
	input wire logic clk_in,
	input wire logic sys_rst_in,
	// command port
	input wire logic [3:0] addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [31:0] rdata_out,
	// clocks to and from the phy, and reset to the phy
	output logic phy_reset_n_out,
	output logic ref_clock_out,
	output logic escape_transmit_clock_out,
	input wire logic escape_receive_clock_in,
	input wire logic fast_word_clock_out_in,
	// phy control
	output logic spread_spectrum_enable_out,
	output logic force_rx_mode_out,
	output logic turn_request_out,
	output logic [3:0] lane_lowpower_tx_request_out,
	output logic [3:0] send_trigger_code_out,
	output logic clock_lane_sleep_enter_out,
	output logic clock_lane_sleep_exit_out,
	output logic [3:0] data_lane_sleep_enter_out,
	output logic [3:0] data_lane_sleep_exit_out,
	// phy status
	input wire logic pll_unlock_in,
	input wire logic clock_lane_idle_state_in,
	input wire logic [3:0] data_lane_idle_state_in,
	input wire logic direction_in,
	input wire logic escape_command_error_in,
	input wire logic line_state_error_in,
	input wire logic contention_error_low_in,
	input wire logic contention_error_high_in,
	input wire logic clock_lane_asleep_low_in,
	input wire logic [3:0] data_lane_asleep_low_in,
	input wire logic [3:0] received_trigger_code_in,
	// fast path
	output logic clock_lane_fast_request_out,
	output logic [3:0] lane_fast_request_valid_out,
	output logic [3:0] lane_deskew_request_out,
	output logic [3:0] lane_upper_byte_valid_out,
	output logic [63:0] lane_fast_tx_word_out,
	input wire logic [3:0] lane_fast_tx_ready_in,
	// low power data
	output logic lowpower_data_tx_mode_out,
	output logic lowpower_tx_byte_valid_out,
	output logic [7:0] lowpower_tx_byte_out,
	input wire logic lowpower_tx_ready_in,
	input wire logic lowpower_data_rx_mode_in,
	input wire logic [7:0] lowpower_rx_byte_in,
	input wire logic lowpower_rx_byte_valid_in,
	input wire logic lowpower_sync_error_in,
	input wire logic lane0_sleep_entered_in
);
	////////////////////////////////////////////////////////////////////////////
	// synchronise everything from the phy
	localparam int sw = 36;
	wire [sw-1:0] raw = {escape_receive_clock_in, fast_word_clock_out_in, pll_unlock_in,
		clock_lane_idle_state_in, data_lane_idle_state_in, direction_in,
		escape_command_error_in, line_state_error_in, contention_error_low_in,
		contention_error_high_in, clock_lane_asleep_low_in, data_lane_asleep_low_in,
		received_trigger_code_in, lane_fast_tx_ready_in, lowpower_tx_ready_in,
		lowpower_data_rx_mode_in, lowpower_rx_byte_valid_in, lowpower_sync_error_in,
		lane0_sleep_entered_in, 5'h00};
	logic [sw-1:0] st;
	logic [sw-1:0] rs;
	sync3 #(.width(sw)) u_sync (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.raw_in(raw),
		.stable_out(st),
		.rise_out(rs)
	);
	// the data byte is only read on a valid edge, by which time it has settled
	logic [7:0] rx_byte_s1;
	logic [7:0] rx_byte_s2;
	wire rxclk_rise = rs[35];
	wire word_rise = rs[34];
	wire [3:0] ready_s = st[13:10];
	wire lp_ready_s = st[9];
	wire [3:0] lane_stat = st[31:28];
	////////////////////////////////////////////////////////////////////////////
	// clock dividers
	logic [3:0] esc_cnt;
	logic [3:0] ref_cnt;
	wire esc_wrap = esc_cnt == phy_host_pkg::esc_half_count;
	wire esc_tick = esc_wrap && escape_transmit_clock_out; // falling edge next: update
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			esc_cnt <= 4'h0;
			ref_cnt <= 4'h0;
			escape_transmit_clock_out <= 1'b0;
			ref_clock_out <= 1'b0;
		end else begin
			esc_cnt <= esc_wrap ? 4'h0 : esc_cnt + 4'h1;
			if (esc_wrap)
				escape_transmit_clock_out <= ~escape_transmit_clock_out;
			ref_cnt <= (ref_cnt == phy_host_pkg::ref_half_count) ? 4'h0 : ref_cnt + 4'h1;
			if (ref_cnt == phy_host_pkg::ref_half_count)
				ref_clock_out <= ~ref_clock_out;
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// registers
	logic [7:0] control;
	logic [31:0] lane_cmd;
	logic [15:0] fast_word;
	logic [3:0] fast_pend;
	logic [7:0] lp_byte;
	logic lp_pend;
	logic [7:0] errors;
	logic [3:0] trig_seen;
	logic [7:0] rx_byte;
	logic rx_full;
	wire wr_ctl = wr_in && addr_in == phy_host_pkg::reg_control;
	wire wr_cmd = wr_in && addr_in == phy_host_pkg::reg_lane_cmd;
	wire wr_word = wr_in && addr_in == phy_host_pkg::reg_fast_word;
	wire wr_lp = wr_in && addr_in == phy_host_pkg::reg_lp_byte;
	wire wr_err = wr_in && addr_in == phy_host_pkg::reg_error;
	wire rd_rx = rd_in && addr_in == phy_host_pkg::reg_rx_byte;
	// a fast word leaves only on a word clock edge with request and ready high
	// only a request already on the pins can meet ready; a fresh one must go out first
	wire [3:0] fast_done = {4{word_rise}} & lane_fast_request_valid_out & ready_s;
	wire lp_done = esc_tick && lowpower_tx_byte_valid_out && lp_ready_s;
	// error events set their bits; the set wins over a write-one clear
	wire [7:0] err_event = {3'h0, rs[6], rs[26], rs[25], rs[24], rs[23]};
	wire [7:0] next_errors = (errors & ~(wr_err ? wdata_in[7:0] : 8'h00)) | err_event;
	wire rx_take = rs[7];
	wire [31:0] status_word = {trig_seen, 1'b0, ~st[21:18], ~st[22], lp_pend, fast_pend, rx_full,
		4'h0, st[33], st[32], st[27], st[5], st[8], 3'h0, lane_stat};
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			control <= phy_host_pkg::control_reset;
			lane_cmd <= 32'h0;
			fast_word <= 16'h0;
			fast_pend <= 4'h0;
			lp_byte <= 8'h0;
			lp_pend <= 1'b0;
			errors <= 8'h0;
			trig_seen <= 4'h0;
			rx_byte_s1 <= 8'h0;
			rx_byte_s2 <= 8'h0;
			rx_byte <= 8'h0;
			rx_full <= 1'b0;
		end else begin
			rx_byte_s1 <= lowpower_rx_byte_in;
			rx_byte_s2 <= rx_byte_s1;
			if (wr_ctl)
				control <= wdata_in[7:0];
			if (wr_cmd)
				lane_cmd <= wdata_in;
			if (wr_word) begin
				fast_word <= wdata_in[15:0];
				fast_pend <= fast_pend | wdata_in[19:16];
			end else
				fast_pend <= fast_pend & ~fast_done;
			if (wr_lp && !lp_pend) begin
				lp_byte <= wdata_in[7:0];
				lp_pend <= 1'b1;
			end else if (lp_done)
				lp_pend <= 1'b0;
			errors <= next_errors;
			if (rxclk_rise && |st[17:14])
				trig_seen <= st[17:14];
			if (rx_take) begin
				rx_byte <= rx_byte_s2;
				rx_full <= 1'b1;
			end else if (rd_rx)
				rx_full <= 1'b0;
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// read data
	logic [31:0] next_rdata;
	always_comb begin
		unique case (addr_in)
			phy_host_pkg::reg_control: next_rdata = {24'h0, control};
			phy_host_pkg::reg_lane_cmd: next_rdata = lane_cmd;
			phy_host_pkg::reg_fast_word: next_rdata = {12'h0, fast_pend, fast_word};
			phy_host_pkg::reg_lp_byte: next_rdata = {23'h0, lp_pend, lp_byte};
			phy_host_pkg::reg_status: next_rdata = status_word;
			phy_host_pkg::reg_error: next_rdata = {24'h0, errors};
			phy_host_pkg::reg_rx_byte: next_rdata = {23'h0, rx_full, rx_byte};
			default: next_rdata = 32'h0;
		endcase
	end
	always_ff @(posedge clk_in) begin
		if (sys_rst_in)
			rdata_out <= 32'h0;
		else
			rdata_out <= rd_in ? next_rdata : 32'h0;
	end
	////////////////////////////////////////////////////////////////////////////
	// phy drive: escape-domain signals change only at escape clock falling edges
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			phy_reset_n_out <= 1'b0;
			spread_spectrum_enable_out <= 1'b0;
			force_rx_mode_out <= 1'b0;
			turn_request_out <= 1'b0;
			lane_lowpower_tx_request_out <= 4'h0;
			send_trigger_code_out <= 4'h0;
			clock_lane_sleep_enter_out <= 1'b0;
			clock_lane_sleep_exit_out <= 1'b0;
			data_lane_sleep_enter_out <= 4'h0;
			data_lane_sleep_exit_out <= 4'h0;
			lowpower_data_tx_mode_out <= 1'b0;
			lowpower_tx_byte_valid_out <= 1'b0;
			lowpower_tx_byte_out <= 8'h0;
			clock_lane_fast_request_out <= 1'b0;
			lane_fast_request_valid_out <= 4'h0;
			lane_deskew_request_out <= 4'h0;
			lane_upper_byte_valid_out <= 4'h0;
			lane_fast_tx_word_out <= 64'h0;
		end else begin
			phy_reset_n_out <= control[phy_host_pkg::ctl_phy_run];
			spread_spectrum_enable_out <= control[phy_host_pkg::ctl_ssc];
			force_rx_mode_out <= control[phy_host_pkg::ctl_force_rx];
			if (esc_tick) begin
				turn_request_out <= control[phy_host_pkg::ctl_turn];
				lane_lowpower_tx_request_out <= lane_cmd[3:0];
				send_trigger_code_out <= lane_cmd[7:4];
				clock_lane_sleep_enter_out <= lane_cmd[8];
				clock_lane_sleep_exit_out <= lane_cmd[9];
				data_lane_sleep_enter_out <= lane_cmd[15:12];
				data_lane_sleep_exit_out <= lane_cmd[19:16];
				lowpower_data_tx_mode_out <= control[phy_host_pkg::ctl_lowpower_data_transfer_mode];
				lowpower_tx_byte_valid_out <= lp_pend && !lp_done;
				lowpower_tx_byte_out <= lp_byte;
			end
			// word-clock signals are updated just after a sampled rising edge
			if (word_rise) begin
				clock_lane_fast_request_out <= control[phy_host_pkg::ctl_clk_fast];
				lane_fast_request_valid_out <= fast_pend & ~fast_done;
				lane_deskew_request_out <= lane_cmd[23:20];
				lane_upper_byte_valid_out <= lane_cmd[27:24];
				if (lane_fast_request_valid_out == 4'h0 || fast_done != 4'h0)
					lane_fast_tx_word_out <= {4{fast_word}};
			end
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// checks
	a_reset_follows: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		!control[phy_host_pkg::ctl_phy_run] |=> !phy_reset_n_out)
		else $error("phy reset released while run bit low");
	a_word_hold: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		lane_fast_request_valid_out[0] && !word_rise |=> $stable(lane_fast_tx_word_out))
		else $error("fast word changed while pending");
	a_esc_period: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		$rose(escape_transmit_clock_out) |=> escape_transmit_clock_out [*2])
		else $error("escape clock high phase too short");
	a_lp_valid: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		lowpower_tx_byte_valid_out |-> lp_pend)
		else $error("low power valid without byte");
	a_err_sticky: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		err_event[0] |=> errors[0])
		else $error("error event lost");
	a_ref_toggle: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		$rose(ref_clock_out) |=> ref_clock_out ##1 !ref_clock_out)
		else $error("reference clock period wrong");
	a_clk_req: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		word_rise |=> clock_lane_fast_request_out == $past(control[phy_host_pkg::ctl_clk_fast]))
		else $error("clock lane request not updated");
	a_rx_capture: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		rx_take |=> rx_full)
		else $error("received byte not captured");
endmodule // phy_host
`default_nettype wire

// File: rtl/phy_host_pkg.sv
package phy_host_pkg;
	localparam int lane_count = 4;
	localparam int word_width = 16;
	// register offsets (word index on the command port)
	localparam logic [3:0] reg_control = 4'h0;
	localparam logic [3:0] reg_lane_cmd = 4'h1;
	localparam logic [3:0] reg_fast_word = 4'h2;
	localparam logic [3:0] reg_lp_byte = 4'h3;
	localparam logic [3:0] reg_status = 4'h4;
	localparam logic [3:0] reg_error = 4'h5;
	localparam logic [3:0] reg_rx_byte = 4'h6;
	// control register fields
	localparam int ctl_phy_run = 0;
	localparam int ctl_ssc = 1;
	localparam int ctl_clk_fast = 2;
	localparam int ctl_force_rx = 3;
	localparam int ctl_lowpower_data_transfer_mode = 4;
	localparam int ctl_turn = 5;
	localparam logic [7:0] control_reset = 8'h00;
	// clocks: system 100 MHz, escape clock below 20 MHz
	localparam int sys_clk_mhz = 100;
	localparam int esc_max_mhz = 20;
	// divide by 6 gives 16.67 MHz: the smallest even ratio under 20 MHz
	localparam int esc_div = ((sys_clk_mhz + esc_max_mhz - 1) / esc_max_mhz + 1) & ~1;
	localparam int esc_half = esc_div / 2;
	localparam logic [3:0] esc_half_count = 4'(esc_half - 1);
	localparam int ref_min_mhz = 12;
	localparam int ref_max_mhz = 52;
	// reference clock: 100/4 = 25 MHz, inside 12..52 MHz
	localparam int ref_div = 4;
	localparam logic [3:0] ref_half_count = 4'(ref_div / 2 - 1);
endpackage

// File: rtl/sync3.sv
`timescale 1ns/1ps
`default_nettype none
// three-stage sampler; a change counts only when stages two and three agree
module sync3 #(
	parameter int width = 1
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic sys_rst_in,
	// raw and filtered
	input wire logic [width-1:0] raw_in,
	output logic [width-1:0] stable_out,
	output logic [width-1:0] rise_out
);
	logic [width-1:0] s1;
	logic [width-1:0] s2;
	logic [width-1:0] s3;
	wire [width-1:0] agree = ~(s2 ^ s3);
	wire [width-1:0] next_stable = (agree & s3) | (~agree & stable_out);
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
			stable_out <= '0;
			rise_out <= '0;
		end else begin
			s1 <= raw_in;
			s2 <= s1;
			s3 <= s2;
			stable_out <= next_stable;
			rise_out <= next_stable & ~stable_out;
		end
	end
endmodule // sync3
`default_nettype wire

// File: verification/phy_model.sv
`timescale 1ns/1ps
`default_nettype none
// behavioural transmit phy; slow_in makes it stall at random
module phy_model (
	// from the controller
	input wire logic reset_n_in,
	input wire logic esc_clk_in,
	input wire logic force_rx_in,
	input wire logic clk_req_in,
	input wire logic [3:0] req_in,
	input wire logic [63:0] word_in,
	input wire logic lp_valid_in,
	input wire logic [7:0] lp_byte_in,
	input wire logic [4:0] sl_en_in,
	input wire logic [4:0] sl_ex_in,
	input wire logic slow_in,
	// to the controller
	output logic wclk_out,
	output logic rx_clk_out,
	output logic [3:0] ready_out,
	output logic lp_ready_out,
	output logic unlock_out,
	output logic clk_idle_out,
	output logic [3:0] idle_out,
	output logic dir_out,
	output logic [4:0] asleep_n_out,
	// what was carried, for the bench
	output logic [3:0] lanes_out,
	output logic [63:0] word_out,
	output int words_out,
	output logic [7:0] byte_out,
	output int bytes_out
);
	initial begin
		wclk_out = 1'b0;
		ready_out = 4'h0;
		lp_ready_out = 1'b0;
		words_out = 0;
		bytes_out = 0;
	end
	// the receive clock echoes the escape clock so that trigger codes get strobed
	assign rx_clk_out = esc_clk_in & reset_n_in;
	assign unlock_out = ~reset_n_in;
	assign clk_idle_out = ~clk_req_in;
	assign idle_out = ~req_in;
	assign dir_out = reset_n_in & force_rx_in;
	always begin
		#40;
		wclk_out = reset_n_in ? ~wclk_out : 1'b0;
	end
	// ready moves on the falling edge so it is settled at the rising one
	always @(negedge wclk_out or negedge reset_n_in) begin
		ready_out <= !reset_n_in ? 4'h0 : (slow_in ? {4{1'($urandom)}} : 4'hf);
	end
	always @(posedge wclk_out) begin
		if ((req_in & ready_out) != 4'h0) begin
			lanes_out <= req_in;
			word_out <= word_in;
			words_out <= words_out + 1;
		end
	end
	always @(posedge esc_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			lp_ready_out <= 1'b0;
			asleep_n_out <= 5'h1f;
		end else begin
			if (lp_valid_in && lp_ready_out) begin
				byte_out <= lp_byte_in;
				bytes_out <= bytes_out + 1;
			end
			lp_ready_out <= slow_in ? 1'($urandom) : 1'b1;
			asleep_n_out <= (asleep_n_out | sl_ex_in) & ~sl_en_in;
		end
	end
endmodule // phy_model
`default_nettype wire

// File: verification/phy_host_tb.sv
`timescale 1ns/1ps
`default_nettype none
module phy_host_tb;
	logic clk_in, sys_rst_in, wr_in, rd_in, slow, rst_n, refc, escc, rxc, wclk, ssc, frx, turn;
	logic csl_en, csl_ex, unlock, cidle, dir, creq, lpm, lpv, lpr;
	logic [3:0] addr_in, trg_in, escr, trg, sl_en, sl_ex, idle, req, desk, upb, rdy, g_l;
	logic [31:0] wdata_in, rdata_out;
	logic [4:0] errs, asl_n;
	logic [63:0] word, g_w;
	logic [7:0] lpb, g_b;
	int words, bytes, fail_count, n_tests;
	phy_host dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .addr_in(addr_in),
		.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
		.phy_reset_n_out(rst_n), .ref_clock_out(refc), .escape_transmit_clock_out(escc),
		.escape_receive_clock_in(rxc), .fast_word_clock_out_in(wclk),
		.spread_spectrum_enable_out(ssc), .force_rx_mode_out(frx), .turn_request_out(turn),
		.lane_lowpower_tx_request_out(escr), .send_trigger_code_out(trg),
		.clock_lane_sleep_enter_out(csl_en), .clock_lane_sleep_exit_out(csl_ex),
		.data_lane_sleep_enter_out(sl_en), .data_lane_sleep_exit_out(sl_ex),
		.pll_unlock_in(unlock), .clock_lane_idle_state_in(cidle), .data_lane_idle_state_in(idle),
		.direction_in(dir), .escape_command_error_in(errs[3]), .line_state_error_in(errs[2]),
		.contention_error_low_in(errs[1]), .contention_error_high_in(errs[0]),
		.clock_lane_asleep_low_in(asl_n[0]), .data_lane_asleep_low_in(asl_n[4:1]),
		.received_trigger_code_in(trg_in), .clock_lane_fast_request_out(creq),
		.lane_fast_request_valid_out(req), .lane_deskew_request_out(desk),
		.lane_upper_byte_valid_out(upb), .lane_fast_tx_word_out(word), .lane_fast_tx_ready_in(rdy),
		.lowpower_data_tx_mode_out(lpm), .lowpower_tx_byte_valid_out(lpv),
		.lowpower_tx_byte_out(lpb), .lowpower_tx_ready_in(lpr), .lowpower_data_rx_mode_in(1'b0),
		.lowpower_rx_byte_in(8'h00), .lowpower_rx_byte_valid_in(1'b0),
		.lowpower_sync_error_in(errs[4]), .lane0_sleep_entered_in(1'b0));
	phy_model phy (.reset_n_in(rst_n), .esc_clk_in(escc), .force_rx_in(frx), .clk_req_in(creq),
		.req_in(req), .word_in(word), .lp_valid_in(lpv), .lp_byte_in(lpb),
		.sl_en_in({sl_en, csl_en}), .sl_ex_in({sl_ex, csl_ex}), .slow_in(slow), .wclk_out(wclk),
		.rx_clk_out(rxc), .ready_out(rdy), .lp_ready_out(lpr), .unlock_out(unlock),
		.clk_idle_out(cidle), .idle_out(idle), .dir_out(dir), .asleep_n_out(asl_n),
		.lanes_out(g_l), .word_out(g_w), .words_out(words), .byte_out(g_b), .bytes_out(bytes));
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clk_in);
		rd_in <= 1'b0;
		#1 d = rdata_out;
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		#400000;
		fail_count++;
		wrap_up();
	end
	initial begin
		logic [31:0] v, r;
		logic [3:0] m;
		int t;
		{sys_rst_in, wr_in, rd_in, slow, addr_in, wdata_in, errs, trg_in} = 49'h1_0000_0000_0000;
		fail_count = 0;
		n_tests = 0;
		void'($urandom(53084));
		repeat (16) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		rd(phy_host_pkg::reg_control, r);
		check({rst_n, r}, {1'b0, 24'h0, phy_host_pkg::control_reset});
		for (int k = 0; k < 6; k++) begin
			v = (k == 0) ? 32'h3f : ($urandom & 32'h3e) | 32'h1;
			wr(phy_host_pkg::reg_control, v);
			repeat (20) @(posedge clk_in);
			check({turn, lpm, frx, creq, ssc, rst_n}, v[5:0]);
			rd(phy_host_pkg::reg_control, r);
			check(r[5:0], v[5:0]);
		end
		for (int k = 0; k < 4; k++) begin
			v = (k == 0) ? 32'h0ffff3ff : $urandom & 32'h0ffff3ff;
			wr(phy_host_pkg::reg_lane_cmd, v);
			repeat (20) @(posedge clk_in);
			check({upb, desk, sl_ex, sl_en, csl_ex, csl_en, trg, escr}, {v[27:12], v[9:0]});
		end
		wr(phy_host_pkg::reg_lane_cmd, 32'h0);
		wr(phy_host_pkg::reg_control, 32'h5);
		for (int k = 0; k < 12; k++) begin
			slow <= k[0];
			v = $urandom & 32'hffff;
			m = (k == 0) ? 4'h1 : (k == 1) ? 4'hf : 4'($urandom % 15 + 1);
			t = words;
			wr(phy_host_pkg::reg_fast_word, {12'h0, m, v[15:0]});
			for (int i = 0; i < 3000 && words == t; i++) @(posedge clk_in);
			check({g_l, g_w}, {m, {4{v[15:0]}}});
			for (int i = 0; i < 300 && req != 4'h0; i++) @(posedge clk_in);
			repeat (40) @(posedge clk_in);
			check(words, t + 1);
		end
		m = 4'($urandom);
		trg_in <= m;
		repeat (20) @(posedge clk_in);
		rd(phy_host_pkg::reg_status, r);
		check({r[31:28], r[21:17], r[3:0]}, {m, 5'h00, 4'hf});
		wr(phy_host_pkg::reg_control, 32'h11);
		for (int k = 0; k < 6; k++) begin
			slow <= k[0];
			v = $urandom & 32'hff;
			t = bytes;
			wr(phy_host_pkg::reg_lp_byte, v);
			// a second byte while the first is pending must be dropped
			if (k == 0) wr(phy_host_pkg::reg_lp_byte, ~v & 32'hff);
			for (int i = 0; i < 3000 && bytes == t; i++) @(posedge clk_in);
			repeat (100) @(posedge clk_in);
			check({g_b, 32'(bytes)}, {v[7:0], 32'(t + 1)});
		end
		for (int k = 0; k < 5; k++) begin
			errs <= 5'h1 << k;
			repeat (10) @(posedge clk_in);
			errs <= 5'h0;
			repeat (10) @(posedge clk_in);
			rd(phy_host_pkg::reg_error, r);
			check(r[4:0], 5'h1 << k);
			wr(phy_host_pkg::reg_error, 32'h1 << k);
			rd(phy_host_pkg::reg_error, r);
			check(r[4:0], 5'h0);
		end
		rd(4'hf, r);
		check(r, 32'h0);
		sys_rst_in <= 1'b1;
		repeat (3) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		rd(phy_host_pkg::reg_control, r);
		check({rst_n, r}, 33'h0);
		wrap_up();
	end
endmodule // phy_host_tb
`default_nettype wire
